// ===== verilog/csrd_pkg.sv
// Constants for the channel settle timer and reference dividers
package csrd_pkg;
	// Register addresses (16-bit word addresses of the register port)
	localparam logic [7:0]  ADDR_SETTLE_CH3  = 8'h13;
	localparam logic [7:0]  ADDR_CLKDIV_CH0  = 8'h14;
	localparam logic [7:0]  ADDR_CLKDIV_CH1  = 8'h15;
	// Register widths and reset values
	localparam int          REG_W            = 16;
	localparam logic [15:0] SETTLE_RESET     = 16'h0000;
	localparam logic [15:0] CLKDIV_RESET     = 16'h0000;
	localparam logic [15:0] RDATA_IDLE       = 16'h0000;
	// Clock divider field layout
	localparam int          DIV_W            = 10;
	localparam int          DIV_LSB          = 0;
	localparam int          PREDIV_LSB       = 12;
	localparam int          PREDIV_W         = 2;
	// Predivide codes
	localparam logic [1:0]  PREDIV_BY1       = 2'h1;
	localparam logic [1:0]  PREDIV_BY2       = 2'h2;
	// Settling interval arithmetic
	localparam int          SETTLE_CNT_W     = 20;
	localparam logic [19:0] SETTLE_MIN_TICKS = 20'h00020;
	localparam int          SETTLE_SHIFT     = 4;
	localparam logic [15:0] SETTLE_SHORT_MAX = 16'h0001;
	// Number of reference dividers in the block
	localparam int          NUM_DIV          = 3;
	// Settle sequencer states
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_SETTLE
	} csrd_state_t;
endpackage : csrd_pkg

// ===== verilog/csrd_div_if.sv
// Divisor and tick bundle between the top and a reference divider
`timescale 1ns/1ps
interface csrd_div_if #(
	parameter int DIV_W = 10
);
	logic [DIV_W-1:0] divisor;
	logic             ref_tick;

	modport ctrl (output divisor, input ref_tick);
	modport div  (input divisor, output ref_tick);
endinterface : csrd_div_if

// ===== verilog/csrd_ref_div.sv
// Reference divider: one tick per divisor cycles of the main clock
`timescale 1ns/1ps
module csrd_ref_div #(
	parameter int DIV_W = 10
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Divisor in, tick out
	csrd_div_if.div   dif
);
	logic [DIV_W-1:0] cnt_ff;
	logic             tick_ff;
	logic             wrap;

	// Zero divisor is reserved; it simply stops the ticks
	assign wrap = (dif.divisor != '0) &&
		(cnt_ff >= dif.divisor - {{(DIV_W-1){1'b0}}, 1'b1});

	// Cycle counter, reloads every divisor cycles
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
		end else if (wrap || dif.divisor == '0) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= cnt_ff + {{(DIV_W-1){1'b0}}, 1'b1};
		end
	end

	// Tick registered so it is a clean one-cycle pulse for any divisor above 1
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= wrap;
		end
	end

	assign dif.ref_tick = tick_ff;
endmodule : csrd_ref_div

// ===== verilog/csrd_top.sv
// Channel settle timer, clock divider registers and reference dividers
`timescale 1ns/1ps
module csrd_top #(
	parameter int DIV_W = csrd_pkg::DIV_W
) (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// Register port
	input  wire logic [7:0]             reg_addr,
	input  wire logic                   reg_wr,
	input  wire logic [15:0]            reg_wdata,
	input  wire logic                   reg_rd,
	output logic      [15:0]            reg_rdata,
	// Channel 3 divisor, held outside this block
	input  wire logic [DIV_W-1:0]       reference_divisor_ch3,
	// Channel 3 conversion control
	input  wire logic                   conv_req_ch3,
	input  wire logic                   amp_settled_ch3,
	input  wire logic                   amp_warn_en,
	output logic                        conv_start_ch3,
	output logic                        settling_ch3,
	output logic                        amp_warning_ch3,
	// Reference ticks and predivide selects
	output logic                        ref_tick_ch0,
	output logic                        ref_tick_ch1,
	output logic                        ref_tick_ch3,
	output logic [1:0]                  sensor_freq_predivide_ch0,
	output logic [1:0]                  sensor_freq_predivide_ch1,
	output logic                        sensor_div2_ch0,
	output logic                        sensor_div2_ch1
);
	logic [15:0]                     settle_count_channel3_ff;
	logic [15:0]                     clock_divide_channel0_ff;
	logic [15:0]                     clock_divide_channel1_ff;
	logic [15:0]                     rdata_ff;
	logic [15:0]                     nxt_rdata;
	logic                            amp_meta_ff;
	logic                            amp_sync_ff;
	csrd_pkg::csrd_state_t           state_ff;
	logic [csrd_pkg::SETTLE_CNT_W-1:0] settle_cnt_ff;
	logic [csrd_pkg::SETTLE_CNT_W-1:0] settle_target_ff;
	logic [csrd_pkg::SETTLE_CNT_W-1:0] nxt_target;
	logic                            start_ff;
	logic                            warn_ff;
	logic                            expire;
	logic                            div2_ch0_ff;
	logic                            div2_ch1_ff;
	logic [csrd_pkg::NUM_DIV-1:0]    ticks;
	logic [DIV_W-1:0]                divs [csrd_pkg::NUM_DIV];

	// Register writes; reserved bits are stored as written
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			settle_count_channel3_ff <= csrd_pkg::SETTLE_RESET;
			clock_divide_channel0_ff <= csrd_pkg::CLKDIV_RESET;
			clock_divide_channel1_ff <= csrd_pkg::CLKDIV_RESET;
		end else if (reg_wr) begin
			case (reg_addr)
				csrd_pkg::ADDR_SETTLE_CH3: begin
					settle_count_channel3_ff <= reg_wdata;
				end
				csrd_pkg::ADDR_CLKDIV_CH0: begin
					clock_divide_channel0_ff <= reg_wdata;
				end
				csrd_pkg::ADDR_CLKDIV_CH1: begin
					clock_divide_channel1_ff <= reg_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		case (reg_addr)
			csrd_pkg::ADDR_SETTLE_CH3: nxt_rdata = settle_count_channel3_ff;
			csrd_pkg::ADDR_CLKDIV_CH0: nxt_rdata = clock_divide_channel0_ff;
			csrd_pkg::ADDR_CLKDIV_CH1: nxt_rdata = clock_divide_channel1_ff;
			default:                   nxt_rdata = csrd_pkg::RDATA_IDLE;
		endcase
	end

	// Read data held in a flop until the next read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= csrd_pkg::RDATA_IDLE;
		end else if (reg_rd) begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;

	// Divisor fields feed the channel 0 and 1 dividers; channel 3 takes reference_divisor_ch3
	assign divs[0] = clock_divide_channel0_ff[csrd_pkg::DIV_LSB +: DIV_W];
	assign divs[1] = clock_divide_channel1_ff[csrd_pkg::DIV_LSB +: DIV_W];
	assign divs[2] = reference_divisor_ch3;

	// One reference divider per channel
	for (genvar g = 0; g < csrd_pkg::NUM_DIV; g++) begin : g_div
		csrd_div_if #(.DIV_W(DIV_W)) dif ();
		assign dif.divisor = divs[g];
		assign ticks[g]    = dif.ref_tick;
		csrd_ref_div #(.DIV_W(DIV_W)) u_div (
			.clk   (clk),
			.rst_n (rst_n),
			.dif   (dif)
		);
	end

	assign ref_tick_ch0 = ticks[0];
	assign ref_tick_ch1 = ticks[1];
	assign ref_tick_ch3 = ticks[2];

	// Predivide select and its divide-by-two decode
	assign sensor_freq_predivide_ch0 =
		clock_divide_channel0_ff[csrd_pkg::PREDIV_LSB +: csrd_pkg::PREDIV_W];
	assign sensor_freq_predivide_ch1 =
		clock_divide_channel1_ff[csrd_pkg::PREDIV_LSB +: csrd_pkg::PREDIV_W];
	// Code 01 leaves the sensor undivided: sensor_div2 stays low
	assign sensor_div2_ch0 = div2_ch0_ff;
	assign sensor_div2_ch1 = div2_ch1_ff;

	// Divide-by-two flags decoded at write time, so the outputs are flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div2_ch0_ff <= 1'b0;
			div2_ch1_ff <= 1'b0;
		end else if (reg_wr && reg_addr == csrd_pkg::ADDR_CLKDIV_CH0) begin
			div2_ch0_ff <= (reg_wdata[csrd_pkg::PREDIV_LSB +:
				csrd_pkg::PREDIV_W] == csrd_pkg::PREDIV_BY2);
		end else if (reg_wr && reg_addr == csrd_pkg::ADDR_CLKDIV_CH1) begin
			div2_ch1_ff <= (reg_wdata[csrd_pkg::PREDIV_LSB +:
				csrd_pkg::PREDIV_W] == csrd_pkg::PREDIV_BY2);
		end
	end

	// Amplitude-settled level comes from the analog side
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			amp_meta_ff <= 1'b0;
			amp_sync_ff <= 1'b0;
		end else begin
			amp_meta_ff <= amp_settled_ch3;
			amp_sync_ff <= amp_meta_ff;
		end
	end

	// Settling length in reference ticks
	always_comb begin
		if (settle_count_channel3_ff <= csrd_pkg::SETTLE_SHORT_MAX) begin
			nxt_target = csrd_pkg::SETTLE_MIN_TICKS;
		end else begin
			nxt_target = {settle_count_channel3_ff,
				csrd_pkg::SETTLE_SHIFT'(0)};
		end
	end

	// Interval ends on the tick that completes the count
	assign expire = (state_ff == csrd_pkg::ST_SETTLE) && ticks[2] &&
		(settle_cnt_ff + 1'b1 >= settle_target_ff);

	// Settle sequencer state; requests while settling are ignored
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= csrd_pkg::ST_IDLE;
		end else begin
			case (state_ff)
				csrd_pkg::ST_IDLE: begin
					if (conv_req_ch3) begin
						state_ff <= csrd_pkg::ST_SETTLE;
					end
				end
				csrd_pkg::ST_SETTLE: begin
					if (expire) begin
						state_ff <= csrd_pkg::ST_IDLE;
					end
				end
				default: begin
					state_ff <= csrd_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Tick counter, held at zero while idle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			settle_cnt_ff <= '0;
		end else if (state_ff == csrd_pkg::ST_IDLE) begin
			settle_cnt_ff <= '0;
		end else if (ticks[2] && !expire) begin
			settle_cnt_ff <= settle_cnt_ff + 1'b1;
		end
	end

	// Target latched at request, so a rewrite cannot stretch a wait
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			settle_target_ff <= csrd_pkg::SETTLE_MIN_TICKS;
		end else if (state_ff == csrd_pkg::ST_IDLE && conv_req_ch3) begin
			settle_target_ff <= nxt_target;
		end
	end

	// Start and warning pulses, one cycle after expiry
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			start_ff <= 1'b0;
			warn_ff  <= 1'b0;
		end else begin
			start_ff <= expire;
			warn_ff  <= expire && !amp_sync_ff && amp_warn_en;
		end
	end

	assign conv_start_ch3  = start_ff;
	assign amp_warning_ch3 = warn_ff;
	assign settling_ch3    = (state_ff == csrd_pkg::ST_SETTLE);
endmodule : csrd_top

// ===== tb/csrd_checker.sv
// Checker for settle timing, warnings and predivide flags
`timescale 1ns/1ps
module csrd_checker #(
	parameter int DIV_W = 10
) (
	// Clock, reset and register writes
	input wire logic             clk,
	input wire logic             rst_n,
	input wire logic             reg_wr,
	input wire logic [7:0]       reg_addr,
	input wire logic [15:0]      reg_wdata,
	// Channel 3 settle control
	input wire logic [DIV_W-1:0] reference_divisor_ch3,
	input wire logic             conv_req_ch3,
	input wire logic             amp_warn_en,
	input wire logic             ref_tick_ch3,
	input wire logic             conv_start_ch3,
	input wire logic             settling_ch3,
	input wire logic             amp_warning_ch3,
	// Channel 0 predivide
	input wire logic [1:0]       sensor_freq_predivide_ch0,
	input wire logic             sensor_div2_ch0
);
	logic [15:0] set_ff;
	logic [19:0] tgt_ff, tcnt_ff;
	logic [1:0]  wsel;
	assign wsel = reg_wdata[13:12];
	// Shadow of the settle register
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n) set_ff <= 16'h0000;
		else if (reg_wr && reg_addr == 8'h13) set_ff <= reg_wdata;
	// Tick target frozen when a request is taken
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n) tgt_ff <= 20'h00000;
		else if (conv_req_ch3 && !settling_ch3)
			tgt_ff <= (set_ff < 16'h0002) ? 20'h00020 : {set_ff, 4'h0};
	// Ticks seen while settling; kept one cycle past the end
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n) tcnt_ff <= 20'h00000;
		else tcnt_ff <= settling_ch3 ? tcnt_ff + 20'(ref_tick_ch3) : 20'h0;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_gap;
		!ref_tick_ch3 [*2] ##1 ref_tick_ch3;
	endsequence
	a_settle_ticks: assert property (
		conv_start_ch3 |-> tcnt_ff == tgt_ff)
		else $error("settle tick count wrong");
	a_tick_period: assert property (ref_tick_ch3 &&
		reference_divisor_ch3 == 3 && $stable(reference_divisor_ch3) |=> s_gap)
		else $error("tick period wrong");
	a_start_ends_settle: assert property (
		conv_start_ch3 |-> $fell(settling_ch3))
		else $error("start without settle end");
	a_start_pulse: assert property (
		conv_start_ch3 |=> !conv_start_ch3)
		else $error("start longer than a cycle");
	a_req_accept: assert property (
		conv_req_ch3 && !settling_ch3 |=> settling_ch3)
		else $error("request not taken");
	a_warn_cause: assert property (
		amp_warning_ch3 |-> conv_start_ch3 && $past(amp_warn_en))
		else $error("warning out of place");
	a_prediv_write: assert property (
		reg_wr && reg_addr == 8'h14 |=> sensor_freq_predivide_ch0 == $past(wsel))
		else $error("predivide wrong");
	a_div2_flag: assert property (
		sensor_div2_ch0 == (sensor_freq_predivide_ch0 == 2'h2))
		else $error("div2 flag wrong");
endmodule : csrd_checker
bind csrd_top csrd_checker #(.DIV_W(DIV_W)) i_csrd_checker (.clk,
	.rst_n, .reg_wr,
	.reg_addr, .reg_wdata, .reference_divisor_ch3, .conv_req_ch3, .amp_warn_en,
	.ref_tick_ch3, .conv_start_ch3, .settling_ch3, .amp_warning_ch3,
	.sensor_freq_predivide_ch0, .sensor_div2_ch0);

// ===== tb/csrd_tank_model.sv
// Resonant tank model: amplitude settles some cycles after excitation
`timescale 1ns/1ps
module csrd_tank_model (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Excitation and slow start select
	input  wire logic excite,
	input  wire logic slow,
	// Settled level
	output logic      amp_settled
);
	logic [7:0] age_ff;
	// Amplitude dies at once when excitation stops, so no stale settle
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n) age_ff <= 8'h00;
		else age_ff <= excite ? age_ff + {7'h0, age_ff != 8'hff} : 8'h00;
	assign amp_settled = age_ff >= (slow ? 8'hc8 : 8'h0a);
endmodule : csrd_tank_model

// ===== tb/channel_settle_and_ref_divider_tb.sv
// Testbench for the settle timer and clock divider registers
`timescale 1ns/1ps
module channel_settle_and_ref_divider_tb;
	logic clk, rst_n, reg_wr, reg_rd, conv_req_ch3, amp_settled_ch3;
	logic amp_warn_en, slow, conv_start_ch3, settling_ch3, amp_warning_ch3;
	logic t0, t1, t3, d0, d1;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic [9:0] div3;
	logic [1:0] p0, p1;
	int n_fail, checked, cyc;
	csrd_top i_csrd_top (.clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
		.reg_rdata, .reference_divisor_ch3(div3), .conv_req_ch3,
		.amp_settled_ch3, .amp_warn_en, .conv_start_ch3, .settling_ch3,
		.amp_warning_ch3, .ref_tick_ch0(t0), .ref_tick_ch1(t1), .ref_tick_ch3(t3),
		.sensor_freq_predivide_ch0(p0), .sensor_freq_predivide_ch1(p1),
		.sensor_div2_ch0(d0), .sensor_div2_ch1(d1));
	csrd_tank_model i_csrd_tank_model (.clk, .rst_n, .excite(settling_ch3),
		.slow, .amp_settled(amp_settled_ch3));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			test_done();
		end
	end
	task chk(input string nm, input logic [15:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk("rdata", reg_rdata, exp);
	endtask : rd
	// Cycles between two ticks of channel 0 or 1
	task per(input logic ch, input logic [15:0] exp);
		int n;
		n = 0;
		while ((ch ? t1 : t0) !== 1'b1) @(posedge clk) #1;
		do begin
			@(posedge clk) #1 n++;
		end while ((ch ? t1 : t0) !== 1'b1);
		chk("tick period", 16'(n), exp);
	endtask : per
	// Second request mid-settle must be ignored, timing unchanged
	task settle(input logic [15:0] s, input logic sl, en, input int t,
		input logic w_exp);
		int n;
		logic w;
		n = 0;
		w = 1'b0;
		wr(8'h13, s);
		@(posedge clk);
		slow <= sl;
		amp_warn_en <= en;
		conv_req_ch3 <= 1'b1;
		do begin
			@(posedge clk);
			conv_req_ch3 <= (n == 4);
			#1 n++;
			w = w | amp_warning_ch3;
		end while (conv_start_ch3 !== 1'b1 && n < 2000);
		chk("settle cycles", 16'(n), 16'(t + 1));
		chk("warning", {15'h0, w}, {15'h0, w_exp});
	endtask : settle
	task test_done;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	initial begin
		rst_n = 1'b0;
		{reg_wr, reg_rd, conv_req_ch3, amp_warn_en, slow} = 5'h00;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		div3 = 10'h001;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h13, 16'h0000);
		rd(8'h15, 16'h0000);
		wr(8'h13, 16'hffff);
		rd(8'h13, 16'hffff);
		rd(8'h20, 16'h0000);
		wr(8'h14, 16'h2005);
		wr(8'h15, 16'h1003);
		rd(8'h14, 16'h2005);
		chk("predivide ch0", {14'h0, p0}, 16'h0002);
		chk("div2 ch0", {15'h0, d0}, 16'h0001);
		chk("predivide ch1", {14'h0, p1}, 16'h0001);
		chk("div2 ch1", {15'h0, d1}, 16'h0000);
		per(1'b0, 16'h0005);
		per(1'b1, 16'h0003);
		settle(16'h0000, 1'b0, 1'b1, 32, 1'b0);
		settle(16'h0001, 1'b1, 1'b1, 32, 1'b1);
		settle(16'h0002, 1'b1, 1'b0, 32, 1'b0);
		settle(16'h0003, 1'b0, 1'b1, 48, 1'b0);
		// Divisor change lands on a rising edge like every other input
		@(posedge clk);
		div3 <= 10'h003;
		repeat (20) @(posedge clk);
		test_done();
	end
endmodule : channel_settle_and_ref_divider_tb
